// >>> rtl/erc_encoder_range_comparator.sv
// Functional notes
// - Point 12 is input twelve by default, comparator output eight when enabled.
// - Host outputs off: continue, force all off, or hold last state.
// - Default absolute mode decodes 8-bit gray into 0 to 255.
// - 360 mode decodes 9-bit excess-76 gray into 0 to 359, rolling over.
// - 512 mode decodes 9-bit gray into 0 to 511.
// - Nine-bit modes use input nine as encoder bit; output five unavailable.
// - 1024 mode decodes 10-bit gray into 0 to 1023.
// - 10-bit mode takes inputs nine and ten; outputs five and six unavailable.
// - Reverse direction swaps up and down counting.
// - Position offset is added within the count range, default zero.
// - Quadrature, marker and preload inputs pass a 20 us or 2 us filter.
// - Quadrature counter wraps between zero and maximum, 10 to 64999.
// - Preload pin or host command loads the preload value.
// - In a home cycle a marker pulse with the home switch on loads the home value.
// - Preset mode holds outputs between presets; timer mode emits pulses.
// - Output turns on when count equals its on-preset.
// - Output turns off when count equals its off-preset.
// - Timer mode: on-preset starts a pulse of timer one ms; zero none.
// - Timer mode: off-preset starts a pulse of timer two ms; zero none.
// - Each sweep exchanges status image and command bits with the host.
// - Status bits: comparators, input nine to twelve levels, strobe latches.
// - Bits 24-29 quadrature only; bit 30 ready; bit 31 error.
// - A set strobe latch blocks further strobes until host reset.
// - Set preload latch blocks preload pin until cleared; command not blocked.
`timescale 1ns/1ps
`include "erc_regs.svh"
module erc_encoder_range_comparator #(
   parameter int MS_CYCLES = `ERC_MS_CYC,
   parameter int NCMP = 16,
   parameter int NTMR = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire erc_pkg::erc_func_e cfgFunction,
   input wire erc_pkg::erc_fallback_e cfgFallback,
   input wire logic cfgReverse,
   input wire logic [15:0] cfgOffset,
   input wire logic cfgFilterShort,
   input wire logic [15:0] cfgMaxCount,
   input wire logic [15:0] cfgPreload,
   input wire logic [15:0] cfgHome,
   input wire logic [3:0] cfgPointOut,
   input wire logic [NTMR-1:0] cfgTimerMode,
   input wire logic [NCMP*16-1:0] cfgOnPreset,
   input wire logic [NCMP*16-1:0] cfgOffPreset,
   input wire logic [NTMR*16-1:0] cfgTimer1,
   input wire logic [NTMR*16-1:0] cfgTimer2,
   // field inputs
   input wire logic [7:0] encLow,
   input wire logic quadA,
   input wire logic quadB,
   input wire logic marker,
   input wire logic preloadPin,
   input wire logic homeSwitch,
   input wire logic [2:0] auxIn,
   input wire logic [3:0] pointIn,
   // host exchange
   input wire logic hostOutputsEnabled,
   input wire logic sweep,
   input wire logic [31:0] cmdBits,
   // field outputs
   output logic [3:0] outLow,
   output logic [3:0] pointOut,
   output logic [3:0] pointOe,
   // status to host
   output logic [31:0] statusImage,
   output logic [15:0] positionWord
);
   import erc_pkg::*;

   logic [31:0] cmd;
   logic [3:0] filtRaw, filt, prevFilt;
   logic [15:0] count, next_count, pos, next_pos, prevPos, maxPos, src;
   logic [15:0] dirPos;
   logic [16:0] sum;
   logic [9:0] gray, bin, t360;
   logic preloadLatched, next_pld, homeFound, next_found;
   erc_home_e homeState, next_home;
   logic fwd, bwd, qUp, qDn, mkRise, pldRise, isQuad, moved;
   logic [31:0] msCnt;
   logic msTick;
   logic [NCMP-1:0] cmpState;
   logic [3:0] encUse, stbLatch, next_stb, prevPoint;
   logic ready, err, next_err, cfgErr;
   logic [7:0] drive, next_drive;
   logic [31:0] st;

   // host command bits act only in the sweep that carries them
   assign cmd = sweep ? cmdBits : 32'h0000_0000;
   assign isQuad = (cfgFunction == ERC_QUAD);
   ////////////////////////////////////////////////////////////////////
   // input filters
   assign filtRaw = {preloadPin, marker, quadB, quadA};
   for (genvar gi = 0; gi < 4; gi++) begin : g_filt
      erc_input_filter #(
         .LONG_CYC(`ERC_FILT_LONG_CYC),
         .SHORT_CYC(`ERC_FILT_SHORT_CYC)
      ) u_filt (
         .clk(clk),
         .rst(rst),
         .shortSel(cfgFilterShort),
         .din(filtRaw[gi]),
         .dout(filt[gi])
      );
   end
   ////////////////////////////////////////////////////////////////////
   // quadrature counter
   assign fwd = (filt[0] ^ prevFilt[0] ^ filt[1] ^ prevFilt[1])
                & (filt[0] ^ prevFilt[1]);
   assign bwd = (filt[0] ^ prevFilt[0] ^ filt[1] ^ prevFilt[1])
                & (filt[1] ^ prevFilt[0]);
   assign qUp = cfgReverse ? bwd : fwd;
   assign qDn = cfgReverse ? fwd : bwd;
   assign mkRise = filt[2] & ~prevFilt[2];
   assign pldRise = filt[3] & ~prevFilt[3];

   always_comb begin
      next_count = count;
      next_pld = preloadLatched;
      next_found = homeFound;
      next_home = homeState;
      if (cmd[`ERC_CMD_PLDCLR])
         next_pld = 1'b0;
      if (cmd[`ERC_CMD_HOME]) begin
         next_home = ERC_HOME_ARMED;
         next_found = 1'b0;
      end
      if (!isQuad) begin
         next_count = 16'h0000;
      end else if (cmd[`ERC_CMD_PRELOAD]) begin
         next_count = cfgPreload;
      end else if (pldRise && !preloadLatched) begin
         next_count = cfgPreload;
         next_pld = 1'b1;
      end else if (homeState == ERC_HOME_ARMED && mkRise && homeSwitch) begin
         next_count = cfgHome;
         next_found = 1'b1;
         next_home = ERC_HOME_IDLE;
      end else if (qUp) begin
         next_count = (count >= cfgMaxCount) ? 16'h0000 : count + 16'h0001;
      end else if (qDn) begin
         next_count = (count == 16'h0000) ? cfgMaxCount : count - 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 16'h0000;
         prevFilt <= 4'h0;
         preloadLatched <= 1'b0;
         homeFound <= 1'b0;
         homeState <= ERC_HOME_IDLE;
      end else begin
         count <= next_count;
         prevFilt <= filt;
         preloadLatched <= next_pld;
         homeFound <= next_found;
         homeState <= next_home;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // gray to binary
   function automatic logic [9:0] erc_gray2bin(input logic [9:0] g);
      logic [9:0] b;
      b = 10'h000;
      for (int i = 0; i < 10; i++)
         b[i] = ^(g >> i);
      return b;
   endfunction

   // upper encoder bits share points nine and ten
   assign gray = {pointIn[1], pointIn[0], encLow};
   assign encUse = {2'h0, cfgFunction == ERC_ABS1024,
                    cfgFunction == ERC_ABS360 || cfgFunction == ERC_ABS512
                    || cfgFunction == ERC_ABS1024};

   always_comb begin
      bin = 10'h000;
      t360 = 10'h000;
      src = count;
      maxPos = cfgMaxCount;
      case (cfgFunction)
         ERC_ABS8: begin
            bin = erc_gray2bin({2'h0, gray[7:0]});
            maxPos = `ERC_MAX_ABS8;
            src = {6'h00, bin};
         end
         ERC_ABS360: begin
            bin = erc_gray2bin({1'h0, gray[8:0]});
            t360 = (bin >= `ERC_EXCESS) ? bin - `ERC_EXCESS
                                        : bin + `ERC_EXCESS_WRAP;
            if (t360 >= `ERC_SPAN360)
               t360 = t360 - `ERC_SPAN360;
            maxPos = `ERC_MAX_ABS360;
            src = {6'h00, t360};
         end
         ERC_ABS512: begin
            bin = erc_gray2bin({1'h0, gray[8:0]});
            maxPos = `ERC_MAX_ABS512;
            src = {6'h00, bin};
         end
         ERC_ABS1024: begin
            bin = erc_gray2bin(gray);
            maxPos = `ERC_MAX_ABS1024;
            src = {6'h00, bin};
         end
         default: begin
            src = count;
            maxPos = cfgMaxCount;
         end
      endcase
      dirPos = (cfgReverse && !isQuad) ? maxPos - src : src;
      sum = {1'b0, dirPos} + {1'b0, cfgOffset};
      if (sum > {1'b0, maxPos})
         sum = sum - ({1'b0, maxPos} + 17'h00001);
      next_pos = sum[15:0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos <= 16'h0000;
         prevPos <= 16'h0000;
      end else begin
         pos <= next_pos;
         prevPos <= pos;
      end
   end
   assign moved = (pos != prevPos);
   ////////////////////////////////////////////////////////////////////
   // millisecond tick for comparator pulses
   always_ff @(posedge clk) begin
      if (rst || msTick)
         msCnt <= 32'h0000_0000;
      else
         msCnt <= msCnt + 32'h0000_0001;
   end
   assign msTick = (msCnt == 32'(MS_CYCLES - 1));
   ////////////////////////////////////////////////////////////////////
   // range comparators
   for (genvar ci = 0; ci < NCMP; ci++) begin : g_cmp
      logic [15:0] onP, offP, t1, t2, tmr, next_tmr;
      logic tm, cs, next_cs;
      assign onP = cfgOnPreset[ci*16 +: 16];
      assign offP = cfgOffPreset[ci*16 +: 16];
      if (ci < NTMR) begin : g_t
         assign tm = cfgTimerMode[ci];
         assign t1 = cfgTimer1[ci*16 +: 16];
         assign t2 = cfgTimer2[ci*16 +: 16];
      end else begin : g_p
         assign tm = 1'b0;
         assign t1 = 16'h0000;
         assign t2 = 16'h0000;
      end
      always_comb begin
         next_tmr = 16'h0000;
         next_cs = cs;
         if (tm) begin
            next_tmr = tmr;
            if (moved && pos == onP)
               next_tmr = t1;
            else if (moved && pos == offP)
               next_tmr = t2;
            else if (msTick && tmr != 16'h0000)
               next_tmr = tmr - 16'h0001;
            next_cs = (next_tmr != 16'h0000);
         end else if (pos == onP) begin
            next_cs = 1'b1;
         end else if (pos == offP) begin
            next_cs = 1'b0;
         end
      end
      always_ff @(posedge clk) begin
         if (rst) begin
            tmr <= 16'h0000;
            cs <= 1'b0;
         end else begin
            tmr <= next_tmr;
            cs <= next_cs;
         end
      end
      assign cmpState[ci] = cs;
   end
   ////////////////////////////////////////////////////////////////////
   // strobes, error, outputs and status image
   always_comb begin
      // latch holds until host reset; set wins
      next_stb = (stbLatch & ~cmd[`ERC_CMD_STBCLR +: 4])
                 | (pointIn & ~prevPoint & ~encUse);
      cfgErr = (cfgOffset > maxPos);
      if (isQuad && (cfgMaxCount < `ERC_QMAX_LO
                     || cfgMaxCount > `ERC_QMAX_HI))
         cfgErr = 1'b1;
      for (int k = 0; k < NCMP; k++)
         if (cfgOnPreset[k*16 +: 16] > maxPos
             || cfgOffPreset[k*16 +: 16] > maxPos)
            cfgErr = 1'b1;
      next_err = (err & ~cmd[`ERC_CMD_ERRCLR]) | cfgErr;
      // fallback when host outputs are off
      if (hostOutputsEnabled || cfgFallback == ERC_CONTINUE)
         next_drive = cmpState[7:0];
      else if (cfgFallback == ERC_FORCE_OFF)
         next_drive = 8'h00;
      else
         next_drive = drive;
      st = `ERC_ST_RESET;
      st[NCMP-1:0] = cmpState;
      st[`ERC_ST_IN +: 4] = pointIn;
      st[`ERC_ST_STB +: 4] = stbLatch;
      if (isQuad) begin
         st[`ERC_ST_HOME] = homeFound;
         st[`ERC_ST_PLD] = preloadLatched;
         st[`ERC_ST_HSW] = homeSwitch;
         st[`ERC_ST_AUX +: 3] = auxIn;
      end
      st[`ERC_ST_RDY] = ready;
      st[`ERC_ST_ERR] = err;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stbLatch <= 4'h0;
         prevPoint <= 4'h0;
         err <= 1'b0;
         ready <= 1'b0;
         drive <= 8'h00;
         outLow <= 4'h0;
         pointOut <= 4'h0;
         pointOe <= 4'h0;
         statusImage <= `ERC_ST_RESET;
         positionWord <= 16'h0000;
      end else begin
         stbLatch <= next_stb;
         prevPoint <= pointIn;
         err <= next_err;
         ready <= 1'b1;
         drive <= next_drive;
         outLow <= next_drive[3:0];
         pointOut <= next_drive[7:4];
         // point becomes output when set in cfgPointOut and not used by encoder
         pointOe <= cfgPointOut & ~encUse;
         // image handed over once per sweep
         if (sweep) begin
            statusImage <= st;
            positionWord <= pos;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // assertions
   property p_force_off;
      @(posedge clk) disable iff (rst)
      !hostOutputsEnabled && cfgFallback == ERC_FORCE_OFF
      |=> outLow == 4'h0 && pointOut == 4'h0;
   endproperty
   a_force_off: assert property (p_force_off)
      else $error("outputs not forced off");

   property p_hold;
      @(posedge clk) disable iff (rst)
      !hostOutputsEnabled && cfgFallback == ERC_HOLD
      |=> $stable(outLow) && $stable(pointOut);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held outputs changed");

   property p_point12;
      @(posedge clk) disable iff (rst)
      1'b1 |=> pointOe[3] == $past(cfgPointOut[3]);
   endproperty
   a_point12: assert property (p_point12)
      else $error("point twelve direction wrong");

   property p_enc_pins;
      @(posedge clk) disable iff (rst)
      cfgFunction == ERC_ABS1024 |=> pointOe[1:0] == 2'h0;
   endproperty
   a_enc_pins: assert property (p_enc_pins)
      else $error("encoder point driven as output");

   property p_wrap;
      @(posedge clk) disable iff (rst)
      isQuad && count == cfgMaxCount && qUp && !qDn && cmd == 32'h0
      && !pldRise && homeState == ERC_HOME_IDLE |=> count == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap to zero");

   property p_cmd_preload;
      @(posedge clk) disable iff (rst)
      isQuad && cmd[`ERC_CMD_PRELOAD] |=> count == $past(cfgPreload);
   endproperty
   a_cmd_preload: assert property (p_cmd_preload)
      else $error("command preload not loaded");

   property p_pld_latch;
      @(posedge clk) disable iff (rst)
      preloadLatched && !cmd[`ERC_CMD_PLDCLR] |=> preloadLatched;
   endproperty
   a_pld_latch: assert property (p_pld_latch)
      else $error("preload latch dropped");

   property p_stb_hold;
      @(posedge clk) disable iff (rst)
      |stbLatch |=> ($past(stbLatch) & ~$past(cmd[`ERC_CMD_STBCLR +: 4])
                     & ~stbLatch) == 4'h0;
   endproperty
   a_stb_hold: assert property (p_stb_hold)
      else $error("strobe latch dropped");

   property p_status;
      @(posedge clk) disable iff (rst)
      sweep |=> statusImage[`ERC_ST_RDY] == $past(ready)
      && statusImage[NCMP-1:0] == $past(cmpState);
   endproperty
   a_status: assert property (p_status)
      else $error("status image mismatch");

   c_home: cover property (@(posedge clk) disable iff (rst)
      !homeFound ##1 homeFound);
   c_timer: cover property (@(posedge clk) disable iff (rst)
      cfgTimerMode[0] && !cmpState[0] ##1 cmpState[0]);
   c_wrap: cover property (@(posedge clk) disable iff (rst)
      isQuad && count == cfgMaxCount ##1 count == 16'h0000);
endmodule // erc_encoder_range_comparator

// >>> rtl/erc_input_filter.sv
`timescale 1ns/1ps
module erc_input_filter #(
   parameter int LONG_CYC = 4000,
   parameter int SHORT_CYC = 400
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filter
   input wire logic shortSel,
   input wire logic din,
   output logic dout
);
   localparam int CW = $clog2(LONG_CYC + 1);
   logic [CW-1:0] cnt, next_cnt, limit;
   logic next_dout;

   // a change is accepted only after it stood for the whole window
   always_comb begin
      limit = shortSel ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
      next_cnt = cnt;
      next_dout = dout;
      if (din == dout) begin
         next_cnt = '0;
      end else if (cnt >= limit) begin
         next_dout = din;
         next_cnt = '0;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= '0;
         dout <= 1'b0;
      end else begin
         cnt <= next_cnt;
         dout <= next_dout;
      end
   end
endmodule // erc_input_filter

// >>> rtl/erc_pkg.sv
package erc_pkg;
   typedef enum logic [2:0] {
      ERC_ABS8, ERC_ABS360, ERC_ABS512, ERC_ABS1024, ERC_QUAD
   } erc_func_e;
   typedef enum logic [1:0] {
      ERC_CONTINUE, ERC_FORCE_OFF, ERC_HOLD
   } erc_fallback_e;
   typedef enum logic {ERC_HOME_IDLE, ERC_HOME_ARMED} erc_home_e;
endpackage

// >>> rtl/erc_regs.svh
`ifndef ERC_REGS_SVH
`define ERC_REGS_SVH
////////////////////////////////////////////////////////////////////////
// clock and timing
`define ERC_CLK_NS 5
`define ERC_FILT_LONG_NS 20000
`define ERC_FILT_SHORT_NS 2000
`define ERC_FILT_LONG_CYC ((`ERC_FILT_LONG_NS+`ERC_CLK_NS-1)/`ERC_CLK_NS)
`define ERC_FILT_SHORT_CYC ((`ERC_FILT_SHORT_NS+`ERC_CLK_NS-1)/`ERC_CLK_NS)
`define ERC_MS_NS 1000000
`define ERC_MS_CYC (`ERC_MS_NS/`ERC_CLK_NS)
////////////////////////////////////////////////////////////////////////
// count ranges
`define ERC_EXCESS 10'h04c
`define ERC_EXCESS_WRAP 10'h11c
`define ERC_SPAN360 10'h168
`define ERC_MAX_ABS8 16'h00ff
`define ERC_MAX_ABS360 16'h0167
`define ERC_MAX_ABS512 16'h01ff
`define ERC_MAX_ABS1024 16'h03ff
`define ERC_QMAX_LO 16'h000a
`define ERC_QMAX_HI 16'hfde7
////////////////////////////////////////////////////////////////////////
// status image bit positions and reset value
`define ERC_ST_IN 16
`define ERC_ST_STB 20
`define ERC_ST_HOME 24
`define ERC_ST_PLD 25
`define ERC_ST_HSW 26
`define ERC_ST_AUX 27
`define ERC_ST_RDY 30
`define ERC_ST_ERR 31
`define ERC_ST_RESET 32'h0000_0000
////////////////////////////////////////////////////////////////////////
// command bit positions
`define ERC_CMD_STBCLR 0
`define ERC_CMD_PRELOAD 4
`define ERC_CMD_PLDCLR 5
`define ERC_CMD_HOME 6
`define ERC_CMD_ERRCLR 7
`endif

// >>> sim/erc_host_model.sv
`timescale 1ns/1ps
module erc_host_model (
   // clock
   input wire logic clk,
   // exchange with the device
   output logic sweep,
   output logic [31:0] cmdBits,
   output logic hostOutputsEnabled,
   input wire logic [31:0] statusImage,
   input wire logic [15:0] positionWord
);
   logic [31:0] st;
   logic [15:0] pos;
   initial begin
      sweep = 1'h0;
      cmdBits = 32'h0;
      hostOutputsEnabled = 1'h1;
      st = 32'h0;
      pos = 16'h0;
   end
   // one sweep exchange
   // commands stand for the one sweep cycle, status taken after that edge
   task automatic xfer(input logic [31:0] cmd);
      @(negedge clk);
      sweep = 1'h1;
      cmdBits = cmd;
      @(negedge clk);
      sweep = 1'h0;
      cmdBits = 32'h0;
      st = statusImage;
      pos = positionWord;
   endtask
endmodule // erc_host_model

// >>> sim/test_erc_encoder_range_comparator.sv
`timescale 1ns/1ps
module test_erc_encoder_range_comparator;
   import erc_pkg::*;
   logic clk, rst, rev, fShort, qa, qb, mk, pPin, hSw;
   erc_func_e fn;
   erc_fallback_e fb;
   logic [15:0] offs, maxC, pld, home, posW;
   logic [3:0] pto, pin, pIn, outLow, pOut, pOe;
   logic [7:0] tMode, enc;
   logic [255:0] onP, offP;
   logic [127:0] tm1, tm2;
   logic [2:0] aux;
   logic [31:0] st, cmd;
   logic sweep, hoe;
   int errors, tests_run;
   // level on points 9..12 from both drivers
   assign pIn = (pOe & pOut) | (~pOe & pin);
   erc_encoder_range_comparator #(.MS_CYCLES(10)) DUT (
      .clk(clk), .rst(rst), .cfgFunction(fn), .cfgFallback(fb),
      .cfgReverse(rev), .cfgOffset(offs), .cfgFilterShort(fShort),
      .cfgMaxCount(maxC), .cfgPreload(pld), .cfgHome(home),
      .cfgPointOut(pto), .cfgTimerMode(tMode), .cfgOnPreset(onP),
      .cfgOffPreset(offP), .cfgTimer1(tm1), .cfgTimer2(tm2),
      .encLow(enc), .quadA(qa), .quadB(qb), .marker(mk),
      .preloadPin(pPin), .homeSwitch(hSw), .auxIn(aux), .pointIn(pIn),
      .hostOutputsEnabled(hoe), .sweep(sweep), .cmdBits(cmd),
      .outLow(outLow), .pointOut(pOut), .pointOe(pOe),
      .statusImage(st), .positionWord(posW));
   erc_host_model host (
      .clk(clk), .sweep(sweep), .cmdBits(cmd), .hostOutputsEnabled(hoe),
      .statusImage(st), .positionWord(posW));
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // drive binary value as gray word, then one exchange
   task automatic go(input logic [9:0] b);
      logic [9:0] g;
      g = b ^ (b >> 1);
      enc = g[7:0];
      pin[1:0] = g[9:8];
      cyc(4);
      host.xfer(32'h0);
   endtask
   task automatic absPos(erc_func_e f, logic [9:0] b, logic [15:0] e);
      fn = f;
      go(b);
      chk("position", {16'h0, e}, {16'h0, host.pos});
   endtask
   task automatic pulse(input int n);
      pPin = 1'h1;
      cyc(n);
      pPin = 1'h0;
      cyc(n);
      host.xfer(32'h0);
      host.xfer(32'h0);
   endtask
   // one quadrature edge, held past the short filter window
   task automatic quad(input logic a, b);
      qa = a;
      qb = b;
      cyc(405);
      host.xfer(32'h0);
   endtask
   task automatic mark;
      mk = 1'h1;
      cyc(405);
      mk = 1'h0;
      cyc(405);
      host.xfer(32'h0);
   endtask
   task automatic summarize;
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tDecode;
      absPos(ERC_ABS8, 10'h0, 16'h0);
      absPos(ERC_ABS8, 10'h0b7, 16'h00b7);
      absPos(ERC_ABS8, 10'h0ff, 16'h00ff);
      absPos(ERC_ABS512, 10'h1ff, 16'h01ff);
      absPos(ERC_ABS1024, 10'h3ff, 16'h03ff);
      absPos(ERC_ABS1024, 10'h2a5, 16'h02a5);
      absPos(ERC_ABS360, 10'h04c, 16'h0);
      absPos(ERC_ABS360, 10'h1b3, 16'h0167);
      absPos(ERC_ABS360, 10'h0, 16'h011c);
      rev = 1'h1;
      absPos(ERC_ABS8, 10'h00a, 16'h00f5);
      rev = 1'h0;
      offs = 16'h00fa;
      absPos(ERC_ABS8, 10'h00a, 16'h0004);
      offs = 16'h012c;
      host.xfer(32'h0);
      host.xfer(32'h0);
      chk("error", 1'h1, host.st[31]);
      chk("quad bits", 6'h0, host.st[29:24]);
      offs = 16'h0;
      host.xfer(32'h80);
      host.xfer(32'h0);
      chk("error", 1'h0, host.st[31]);
   endtask
   task automatic tCompare;
      onP[15:0] = 16'h000a;
      offP[15:0] = 16'h0014;
      go(10'h014);
      chk("out1", 1'h0, outLow[0]);
      go(10'h00a);
      chk("out1", 1'h1, outLow[0]);
      go(10'h00f);
      chk("out1", 1'h1, outLow[0]);
      chk("status0", 1'h1, host.st[0]);
      fb = ERC_HOLD;
      host.hostOutputsEnabled = 1'h0;
      go(10'h014);
      chk("out1", 1'h1, outLow[0]);
      fb = ERC_FORCE_OFF;
      go(10'h00a);
      chk("out1", 1'h0, outLow[0]);
      fb = ERC_CONTINUE;
      go(10'h00a);
      chk("out1", 1'h1, outLow[0]);
      host.hostOutputsEnabled = 1'h1;
      go(10'h014);
      chk("out1", 1'h0, outLow[0]);
   endtask
   task automatic tTimer;
      tMode[0] = 1'h1;
      tm1[15:0] = 16'h0002;
      tm2[15:0] = 16'h0003;
      go(10'h005);
      go(10'h00a);
      chk("pulse on", 1'h1, outLow[0]);
      cyc(30);
      chk("pulse end", 1'h0, outLow[0]);
      go(10'h014);
      chk("pulse off", 1'h1, outLow[0]);
      cyc(40);
      chk("pulse end", 1'h0, outLow[0]);
      tm1[15:0] = 16'h0;
      go(10'h00a);
      chk("no pulse", 1'h0, outLow[0]);
      tMode[0] = 1'h0;
   endtask
   task automatic tPoints;
      fn = ERC_ABS8;
      go(10'h0);
      chk("oe", 4'h0, pOe);
      onP[127:112] = 16'h001e;
      offP[127:112] = 16'h0028;
      pto = 4'hf;
      go(10'h01e);
      chk("oe", 4'hf, pOe);
      chk("out8", 1'h1, pOut[3]);
      fn = ERC_ABS512;
      go(10'h01e);
      chk("oe", 4'he, pOe);
      fn = ERC_ABS1024;
      go(10'h01e);
      chk("oe", 4'hc, pOe);
      fn = ERC_ABS8;
      pto = 4'h0;
      pin[3] = 1'h1;
      go(10'h0);
      host.xfer(32'h0);
      chk("in12", 1'h1, host.st[19]);
      chk("strobe4", 1'h1, host.st[23]);
      host.xfer(32'h8);
      host.xfer(32'h0);
      chk("strobe4", 1'h0, host.st[23]);
   endtask
   task automatic tQuad;
      fn = ERC_QUAD;
      pld = 16'h007b;
      host.xfer(32'h10);
      host.xfer(32'h0);
      chk("position", 16'h007b, host.pos);
      chk("sw aux", 4'hb, host.st[29:26]);
      pld = 16'h0007;
      pulse(450);
      chk("position", 16'h007b, host.pos);
      fShort = 1'h1;
      pulse(450);
      chk("position", 16'h0007, host.pos);
      chk("latch", 1'h1, host.st[25]);
      pld = 16'h0009;
      pulse(450);
      chk("position", 16'h0007, host.pos);
      host.xfer(32'h10);
      host.xfer(32'h20);
      host.xfer(32'h0);
      chk("position", 16'h0009, host.pos);
      chk("latch", 1'h0, host.st[25]);
   endtask
   task automatic tCount;
      maxC = 16'h0064;
      pld = 16'h0064;
      home = 16'h0032;
      host.xfer(32'h10);
      quad(1'h1, 1'h0);
      chk("position", 16'h0000, host.pos);
      quad(1'h0, 1'h0);
      chk("position", 16'h0064, host.pos);
      rev = 1'h1;
      quad(1'h1, 1'h0);
      chk("position", 16'h0063, host.pos);
      rev = 1'h0;
      hSw = 1'h0;
      aux = 3'h2;
      host.xfer(32'h40);
      mark();
      chk("position", 16'h0063, host.pos);
      hSw = 1'h1;
      mark();
      chk("position", 16'h0032, host.pos);
      chk("quad bits", 6'h15, host.st[29:24]);
      chk("error", 1'h1, host.st[31]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      {rev, fShort, qa, qb, mk, pPin} = 6'h0;
      hSw = 1'h1;
      aux = 3'h5;
      fn = ERC_ABS8;
      fb = ERC_CONTINUE;
      {offs, pld, home} = 48'h0;
      maxC = 16'h00ff;
      {pto, pin, tMode, enc} = 24'h0;
      onP = {16{16'h00ff}};
      offP = 256'h0;
      {tm1, tm2} = 256'h0;
      errors = 0;
      tests_run = 0;
      cyc(5);
      rst = 1'h0;
      chk("out", 4'h0, outLow);
      host.xfer(32'h0);
      host.xfer(32'h0);
      chk("ready", 2'h1, host.st[31:30]);
      tDecode();
      tCompare();
      tTimer();
      tPoints();
      tQuad();
      tCount();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule // test_erc_encoder_range_comparator
